// ---- hdl/epa_partner_word.sv ----
/*
  Builds the emulated partner's base-page ability word from the local
  pause advertisement. Purely combinational; the caller registers it.
*/
module epa_partner_word
(
  input wire logic adv_sym_pause,
  input wire logic adv_asym_pause,
  output logic [15:0] ability_word
);

  import epa_pkg::*;

  always_comb
  begin
    ability_word = 16'h0000;
    ability_word[SEL_MSB:SEL_LSB] = SELECTOR_8023;
    ability_word[ABIL_MSB:ABIL_LSB] = PARTNER_ABILITIES;
    // Partner symmetric pause is local sym XOR asym; partner asymmetric copies local asym
    ability_word[SYM_PAUSE_BIT] = adv_sym_pause ^ adv_asym_pause;
    ability_word[ASYM_PAUSE_BIT] = adv_asym_pause;
    // Four-pair, remote fault and next page bits stay clear
    ability_word[T4_BIT] = 1'b0;
    ability_word[REMOTE_FAULT_BIT] = 1'b0;
    ability_word[NEXT_PAGE_BIT] = 1'b0;
  end

endmodule

// ---- hdl/epa_regs.sv ----
/*
  Emulated link partner status registers: partner ability word and the
  auto-negotiation expansion register, readable as 32-bit host words and
  as 16-bit management registers. Assumes inputs synchronous to clk; the
  host and management paths are answered independently, even in the same cycle.
*/
// What this block does
// - The partner ability word always shows the four 10/100 half and full duplex bits 8:5 as one.
// - The selector field in bits 4:0 of the partner word always reads 00001.
// - Each register is a 32-bit host word with bits 31:16 zero and a 16-bit serial register.
// - The partner has no next page and sends its base page at once when negotiation runs.
// - The partner never signals remote fault and never claims four-pair capability.
// - Partner pause bits follow local pause: none gives none, symmetric only gives symmetric.
// - Local asymmetric only gives partner both bits; both local bits give asymmetric only.
// - The expansion register answers at host offset 0x1d8 and at management index 6.
// - The parallel detection fault bit 4 of the expansion register always reads zero.
// - Both next-page-able bits 3 and 2 of the expansion register always read zero.
// - The page received bit 1 latches high on a new page and clears on a read.
// - Reset clears page received, and the negotiation run right after reset sets it.
// - Partner negotiation-able bit 0 reads one unless local and partner abilities share no bit.
// - Bit 9 of the partner word, four-pair capability, always reads zero.
module epa_regs
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic host_rd_en,
  input wire logic [epa_pkg::HOST_ADDR_W-1:0] host_addr,
  output logic [31:0] host_rd_data_q,
  output logic host_rd_valid_q,
  input wire logic mgmt_rd_en,
  input wire logic [epa_pkg::MGMT_IDX_W-1:0] mgmt_reg_idx,
  output logic [15:0] mgmt_rd_data_q,
  output logic mgmt_rd_valid_q,
  input wire logic adv_sym_pause,
  input wire logic adv_asym_pause,
  input wire logic [3:0] local_adv_ability,
  input wire logic an_restart
);

  import epa_pkg::*;

  logic [15:0] partner_word;
  logic [15:0] exp_now;
  logic host_hit_exp;
  logic host_hit_partner;
  logic mgmt_hit_exp;
  logic mgmt_hit_partner;
  logic page_clear;
  logic page_set;

  epa_neg_state_type st_q, st_d;
  logic page_rx_q, page_rx_d;
  logic an_able_q, an_able_d;
  logic [31:0] host_rd_data_d;
  logic host_rd_valid_d;
  logic [15:0] mgmt_rd_data_d;
  logic mgmt_rd_valid_d;

  epa_partner_word u_partner_word
  (
    .adv_sym_pause(adv_sym_pause),
    .adv_asym_pause(adv_asym_pause),
    .ability_word(partner_word)
  );

  // Address decode for both read paths
  always_comb
  begin
    host_hit_exp = host_rd_en && (host_addr == EXP_OFFSET);
    host_hit_partner = host_rd_en && (host_addr == PARTNER_OFFSET);
    mgmt_hit_exp = mgmt_rd_en && (mgmt_reg_idx == EXP_INDEX);
    mgmt_hit_partner = mgmt_rd_en && (mgmt_reg_idx == PARTNER_INDEX);
  end

  // Negotiation: one cycle to exchange the base page, then wait for a restart
  always_comb
  begin
    st_d = st_q;
    page_set = 1'b0;
    an_able_d = an_able_q;
    case (st_q)
      neg_start:
      begin
        // No wait and no next page: the base page lands immediately
        page_set = 1'b1;
        an_able_d = |(local_adv_ability & PARTNER_ABILITIES);
        st_d = neg_done;
      end
      neg_done:
      begin
        if (an_restart)
        begin
          st_d = neg_start;
        end
      end
      default:
      begin
        st_d = neg_start;
      end
    endcase
  end

  // Page received: a new page wins over a read in the same cycle
  always_comb
  begin
    page_clear = host_hit_exp || mgmt_hit_exp;
    if (page_set)
    begin
      page_rx_d = 1'b1;
    end
    else if (page_clear)
    begin
      page_rx_d = 1'b0;
    end
    else
    begin
      page_rx_d = page_rx_q;
    end
  end

  // Read answers carry the flag value from before the clear
  always_comb
  begin
    exp_now = exp_word(page_rx_q, an_able_q);
    host_rd_valid_d = host_rd_en;
    mgmt_rd_valid_d = mgmt_rd_en;
    // Upper half is padding; unmapped addresses read zero
    host_rd_data_d = HOST_DATA_RST;
    if (host_hit_exp)
    begin
      host_rd_data_d = {16'h0000, exp_now};
    end
    else if (host_hit_partner)
    begin
      host_rd_data_d = {16'h0000, partner_word};
    end
    mgmt_rd_data_d = MGMT_DATA_RST;
    if (mgmt_hit_exp)
    begin
      mgmt_rd_data_d = exp_now;
    end
    else if (mgmt_hit_partner)
    begin
      mgmt_rd_data_d = partner_word;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= neg_start;
      page_rx_q <= PAGE_RX_RST;
      an_able_q <= AN_ABLE_RST;
      host_rd_data_q <= HOST_DATA_RST;
      host_rd_valid_q <= 1'b0;
      mgmt_rd_data_q <= MGMT_DATA_RST;
      mgmt_rd_valid_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      page_rx_q <= page_rx_d;
      an_able_q <= an_able_d;
      host_rd_data_q <= host_rd_data_d;
      host_rd_valid_q <= host_rd_valid_d;
      mgmt_rd_data_q <= mgmt_rd_data_d;
      mgmt_rd_valid_q <= mgmt_rd_valid_d;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  partner_abil_a: assert property (host_hit_partner |=>
    host_rd_data_q[ABIL_MSB:ABIL_LSB] == PARTNER_ABILITIES)
    else $error("partner ability bits not all one");

  selector_val_a: assert property (mgmt_hit_partner |=>
    mgmt_rd_data_q[SEL_MSB:SEL_LSB] == SELECTOR_8023)
    else $error("selector field wrong");

  upper_pad_a: assert property (host_rd_en |=> host_rd_data_q[31:16] == 16'h0000)
    else $error("host padding bits not zero");

  fixed_clear_a: assert property (host_hit_partner |=>
    !host_rd_data_q[T4_BIT] && !host_rd_data_q[REMOTE_FAULT_BIT]
    && !host_rd_data_q[NEXT_PAGE_BIT])
    else $error("four-pair, fault or next page bit set");

  pause_map_a: assert property (mgmt_hit_partner |=>
    mgmt_rd_data_q[SYM_PAUSE_BIT] == ($past(adv_sym_pause) ^ $past(adv_asym_pause))
    && mgmt_rd_data_q[ASYM_PAUSE_BIT] == $past(adv_asym_pause))
    else $error("partner pause bits do not follow local advert");

  exp_zero_a: assert property (mgmt_hit_exp |=> mgmt_rd_data_q[15:2] == 14'h0000)
    else $error("expansion fixed bits not zero");

  page_clear_a: assert property (page_clear && !page_set |=> !page_rx_q)
    else $error("page received not cleared by read");

  restart_page_a: assert property (st_q == neg_done && an_restart
    |-> ##[1:2] page_rx_q)
    else $error("page not received after restart");

  an_able_a: assert property (st_q == neg_start |=>
    an_able_q == |($past(local_adv_ability) & PARTNER_ABILITIES))
    else $error("negotiation-able flag wrong");

  set_wins_a: assert property (page_set |=> page_rx_q)
    else $error("new page lost to a read in the same cycle");

  np_zero_a: assert property (host_hit_exp |=>
    host_rd_data_q[PARTNER_NP_BIT:LOCAL_NP_BIT] == 2'b00)
    else $error("next page able bits not zero");

  t4_zero_a: assert property (mgmt_hit_partner |=> !mgmt_rd_data_q[T4_BIT])
    else $error("four-pair bit set on management read");

  exp_answer_a: assert property (host_hit_exp |=> host_rd_valid_q)
    else $error("expansion read not answered");

  read_page_c: cover property (mgmt_hit_exp ##1 mgmt_rd_data_q[PAGE_RX_BIT]);
  neg_fail_c: cover property (st_q == neg_start ##1 !an_able_q);
  set_vs_clear_c: cover property (page_set && page_clear);
  host_exp_c: cover property (host_hit_exp ##1 host_rd_valid_q);

endmodule

// ---- inc/epa_pkg.sv ----
/*
  Constants for the emulated link partner status registers: host offsets,
  management indices, field positions, fixed field values and reset values.
  Assumes a single system clock domain and an active-low asynchronous reset.
*/
package epa_pkg;

  localparam int HOST_ADDR_W = 12;
  localparam int MGMT_IDX_W = 5;

  // Host-side word offsets (byte addresses)
  localparam logic [11:0] EXP_OFFSET = 12'h1d8;
  localparam logic [11:0] PARTNER_OFFSET = 12'h1d4;

  // Serial management register indices
  localparam logic [4:0] EXP_INDEX = 5'h06;
  localparam logic [4:0] PARTNER_INDEX = 5'h05;

  // Partner ability word field positions
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 4;
  localparam int ABIL_LSB = 5;
  localparam int ABIL_MSB = 8;
  localparam int T4_BIT = 9;
  localparam int SYM_PAUSE_BIT = 10;
  localparam int ASYM_PAUSE_BIT = 11;
  localparam int REMOTE_FAULT_BIT = 13;
  localparam int NEXT_PAGE_BIT = 15;

  localparam logic [4:0] SELECTOR_8023 = 5'h01;
  localparam logic [3:0] PARTNER_ABILITIES = 4'hf;

  // Expansion register field positions
  localparam int AN_ABLE_BIT = 0;
  localparam int PAGE_RX_BIT = 1;
  localparam int LOCAL_NP_BIT = 2;
  localparam int PARTNER_NP_BIT = 3;
  localparam int PAR_DET_FAULT_BIT = 4;

  // Reset values
  localparam logic PAGE_RX_RST = 1'b0;
  localparam logic AN_ABLE_RST = 1'b1;
  localparam logic [31:0] HOST_DATA_RST = 32'h0000_0000;
  localparam logic [15:0] MGMT_DATA_RST = 16'h0000;

  typedef enum logic [1:0]
  {
    neg_start,
    neg_done
  } epa_neg_state_type;

  // Expansion word as seen by both read paths; fixed bits stay zero
  function automatic logic [15:0] exp_word(input logic page_rx, input logic an_able);
    logic [15:0] w;
    w = 16'h0000;
    w[PAGE_RX_BIT] = page_rx;
    w[AN_ABLE_BIT] = an_able;
    return w;
  endfunction

endpackage

// ---- tb/epa_mgmt_station.sv ----
/*
  Management station model: issues 16-bit register reads by index.
  Assumes read() is called at a rising edge and never twice in a row.
*/
module epa_mgmt_station
  import epa_pkg::*;
(
  input wire logic clk,
  output logic mgmt_rd_en,
  output logic [epa_pkg::MGMT_IDX_W-1:0] mgmt_reg_idx
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    mgmt_rd_en = 1'b0;
    mgmt_reg_idx = 5'h00;
  end
  // Index is scrambled once released so a stale index cannot pass for a live one
  task automatic read(input logic [4:0] idx);
    mgmt_rd_en <= 1'b1;
    mgmt_reg_idx <= idx;
    @(posedge clk);
    mgmt_rd_en <= 1'b0;
    mgmt_reg_idx <= ~idx;
  endtask
endmodule

// ---- tb/test_emulated_partner_autoneg_regs.sv ----
/*
  Self-checking bench for the emulated partner status registers.
  Assumes the host and management paths may be read in the same cycle.
*/
module test_emulated_partner_autoneg_regs import epa_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic host_rd_en = 1'b0;
  logic [11:0] host_addr = 12'h000;
  logic adv_sym_pause = 1'b0;
  logic adv_asym_pause = 1'b0;
  logic [3:0] local_adv_ability = 4'hf;
  logic an_restart = 1'b0;
  logic [31:0] host_rd_data_q;
  logic host_rd_valid_q;
  logic mgmt_rd_en;
  logic [4:0] mgmt_reg_idx;
  logic [15:0] mgmt_rd_data_q;
  logic mgmt_rd_valid_q;
  logic [31:0] host_q[$];
  logic [15:0] mgmt_q[$];
  int errors = 0;
  int check_count = 0;
  logic [31:0] u;

  always #25 clk = ~clk;

  epa_regs DUT (.clk(clk), .resetn(resetn), .host_rd_en(host_rd_en), .host_addr(host_addr),
    .host_rd_data_q(host_rd_data_q), .host_rd_valid_q(host_rd_valid_q),
    .mgmt_rd_en(mgmt_rd_en), .mgmt_reg_idx(mgmt_reg_idx), .mgmt_rd_data_q(mgmt_rd_data_q),
    .mgmt_rd_valid_q(mgmt_rd_valid_q), .adv_sym_pause(adv_sym_pause),
    .adv_asym_pause(adv_asym_pause), .local_adv_ability(local_adv_ability),
    .an_restart(an_restart));
  epa_mgmt_station station (.clk(clk), .mgmt_rd_en(mgmt_rd_en), .mgmt_reg_idx(mgmt_reg_idx));

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp32(what, {16'h0000, exp}, {16'h0000, got});
  endtask

  function automatic logic [15:0] partner_word(input logic s, input logic a);
    partner_word = 16'h01e1;  // Fixed abilities and selector
    // Pause table: partner {asym, sym} for each local {sym, asym}
    case ({s, a})
      2'b10: partner_word[11:10] = 2'b01;
      2'b01: partner_word[11:10] = 2'b11;
      2'b11: partner_word[11:10] = 2'b10;
      default: partner_word[11:10] = 2'b00;
    endcase
  endfunction

  task automatic host_read(input logic [11:0] addr, input logic [31:0] exp);
    host_rd_en <= 1'b1;
    host_addr <= addr;
    host_q.push_back(exp);
    @(posedge clk);
  endtask

  task automatic mgmt_read(input logic [4:0] idx, input logic [15:0] exp);
    mgmt_q.push_back(exp);
    station.read(idx);
  endtask

  task automatic idle(input int n);
    host_rd_en <= 1'b0;
    host_addr <= ~host_addr;
    an_restart <= 1'b0;
    repeat (n) @(posedge clk);
  endtask

  task automatic restart(input logic [3:0] abil);
    local_adv_ability <= abil;
    an_restart <= 1'b1;
    @(posedge clk);
    idle(3);
  endtask

  // Unrequested answers meet an unknown expectation and so always mismatch
  always @(negedge clk)
  begin
    if (host_rd_valid_q === 1'b1)
      cmp32("host word", host_q.size() ? host_q.pop_front() : 'x, host_rd_data_q);
    if (mgmt_rd_valid_q === 1'b1)
      cmp16("mgmt word", mgmt_q.size() ? mgmt_q.pop_front() : 'x, mgmt_rd_data_q);
  end

  initial
  begin
    u = $urandom(32'heb7bf337);
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    idle(3);
    host_read(EXP_OFFSET, 32'h0000_0003);
    host_read(EXP_OFFSET, 32'h0000_0001);
    idle(1);
    for (int i = 0; i < 4; i++)
    begin
      adv_sym_pause <= i[0];
      adv_asym_pause <= i[1];
      @(posedge clk);
      host_read(PARTNER_OFFSET, {16'h0000, partner_word(i[0], i[1])});
      idle(1);
      mgmt_read(PARTNER_INDEX, partner_word(i[0], i[1]));
      idle(1);
    end
    restart(4'h0);
    mgmt_read(EXP_INDEX, 16'h0002);
    idle(1);
    mgmt_read(EXP_INDEX, 16'h0000);
    idle(1);
    u = $urandom();
    restart(u[3:0] == 4'h0 ? 4'h8 : u[3:0]);
    fork
      host_read(EXP_OFFSET, 32'h0000_0003);
      mgmt_read(EXP_INDEX, 16'h0003);
    join
    u = $urandom();
    host_read(EXP_OFFSET, 32'h0000_0001);
    host_read(12'h800 | u[11:0], 32'h0000_0000);
    idle(1);
    mgmt_read(5'h10 | u[20:16], 16'h0000);
    idle(1);
    // A read in the cycle the new page lands must not win over it
    local_adv_ability <= 4'h1;
    an_restart <= 1'b1;
    @(posedge clk);
    an_restart <= 1'b0;
    host_read(EXP_OFFSET, 32'h0000_0001);
    host_read(EXP_OFFSET, 32'h0000_0003);
    idle(1);
    // Reset in mid-run with the page flag set: reset clears it, the first run sets it again
    restart(4'h2);
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    host_read(EXP_OFFSET, 32'h0000_0001);
    host_read(EXP_OFFSET, 32'h0000_0003);
    idle(1);
    for (int i = 0; i < 10 && (host_q.size() + mgmt_q.size()) > 0; i++)
      @(posedge clk);
    if (host_q.size() + mgmt_q.size() > 0)
    begin
      errors++;
      $display("unexpected pending reads expected 0 seen %0d", host_q.size() + mgmt_q.size());
    end
    end_sim();
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    end_sim();
  end
endmodule
